// ===== rtl/pfsc_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: control clock of 4 ns
// Notes:   included by bare name
`ifndef PFSC_REGS_SVH
`define PFSC_REGS_SVH

// register offsets
`define PFSC_CONV_SWITCH_SELECT_OFS  8'h0a
`define PFSC_AUX_RESET_PIN_SEL_OFS   8'h3d
`define PFSC_EXTRA_EN_ONE_SEL_OFS    8'h3e
`define PFSC_EXTRA_EN_TWO_SEL_OFS    8'h3f

// reset values
`define PFSC_CONV_SWITCH_SELECT_RST  8'h00
`define PFSC_AUX_RESET_PIN_SEL_RST   8'h00
`define PFSC_EXTRA_EN_ONE_SEL_RST    8'h00
`define PFSC_EXTRA_EN_TWO_SEL_RST    8'h00

// field positions
`define PFSC_CONV1_INTERNAL_SWITCH_BIT 0
`define PFSC_CONV2_INTERNAL_SWITCH_BIT 1
`define PFSC_AUX_RESET_ONE_LSB       0
`define PFSC_AUX_RESET_ONE_MSB       1
`define PFSC_AUX_RESET_TWO_LSB       4
`define PFSC_AUX_RESET_TWO_MSB       5

// channel-group codes of the aux reset fields
`define PFSC_GROUP_NONE              2'h0
`define PFSC_GROUP_ALWAYS_ON         2'h1
`define PFSC_GROUP_EXTRA_ONE         2'h2
`define PFSC_GROUP_EXTRA_TWO         2'h3

// timing
`define PFSC_CLK_PERIOD_NS           4
`define PFSC_DEBOUNCE_NS             10000
`define PFSC_DEBOUNCE_CYC \
  ((`PFSC_DEBOUNCE_NS + `PFSC_CLK_PERIOD_NS - 1) / `PFSC_CLK_PERIOD_NS)

`endif

// ===== rtl/pfsc_pkg.sv
// Purpose: types of the pin function and standby control block
// Assumes: nothing
// Notes:   constants live in pfsc_regs.svh
package pfsc_pkg;

  typedef logic [11:0] pfsc_cnt_t;

  typedef enum logic [3:0] {
    PFSC_OFF     = 4'h1,
    PFSC_INIT    = 4'h2,
    PFSC_ACTIVE  = 4'h4,
    PFSC_STANDBY = 4'h8
  } pfsc_state_e;

  typedef struct packed {
    logic      level;
    pfsc_cnt_t cnt;
  } pfsc_deb_s;

  typedef struct packed {
    pfsc_state_e state;
    logic [7:0]  conv_sel;
    logic [7:0]  aux_sel;
    logic [7:0]  en1_sel;
    logic [7:0]  en2_sel;
    logic [7:0]  rdata;
    logic        wr_refused;
    logic        full_init_start;
    logic        fast_start;
    logic        in_standby;
    logic        run;
    logic        link_clock;
    logic        sync_clock;
    logic        conv1_switch_node;
    logic        conv2_switch_node;
    logic        int_oe_n;
    logic        err_oe_n;
    logic        host_rst_oe_n;
    logic [7:0]  ch_enable;
    logic [2:0]  pin_level;
  } pfsc_top_s;

endpackage : pfsc_pkg

// ===== rtl/pfsc_debounce.sv
// Purpose: pass an input level only after it held stable 10 us
// Assumes: din synchronous to clk
// Notes:   dout starts low after reset
`timescale 1ns/1ps
`default_nettype none
`include "pfsc_regs.svh"

module pfsc_debounce (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // level
  input  wire logic din,
  output var  logic dout
);

  localparam pfsc_pkg::pfsc_cnt_t DEB_LAST =
    12'(`PFSC_DEBOUNCE_CYC - 1);

  pfsc_pkg::pfsc_deb_s s_reg;
  pfsc_pkg::pfsc_deb_s s_next;

  always_comb begin
    s_next = s_reg;
    if (din == s_reg.level) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == DEB_LAST) begin
      s_next.level = din;
      s_next.cnt   = '0;
    end else begin
      s_next.cnt = s_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.level;

endmodule // pfsc_debounce
`default_nettype wire

// ===== rtl/pfsc_top.sv
// Purpose: multipurpose pin function select and standby/enable control
// Assumes: pins and register port synchronous to the 250 MHz clock
// Notes:   open-drain pins drive low only; oe_n low means pulling down
//
// Operation
// - extra-enable-one select zero: pin is link clock
// - select nonzero: pin enables assigned channels
// - debounce extra enable one for 10 us
// - extra-enable-two select zero: pin is sync clock
// - select nonzero: pin enables assigned channels
// - debounce extra enable two for 10 us
// - aux reset one zero: interrupt open-drain output
// - nonzero: power-good reset of selected group
// - aux reset two zero: error open-drain output
// - nonzero: power-good reset of selected group
// - converter 1 bit: switch node or sense
// - converter 2 bit: switch node or sense
// - debounce enable input for 10 us
// - debounce standby request for 10 us
// - standby request high: standby when enable drops
// - re-enable from standby skips checks and loading
// - standby low: full initialization on every enable
// - guarded registers writable only in standby
// - active-low open-drain reset toward host
`timescale 1ns/1ps
`default_nettype none
`include "pfsc_regs.svh"

module pfsc_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // register port from the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_wr_refused,
  // control inputs
  input  wire logic       enable_in,
  input  wire logic       standby_request,
  input  wire logic       init_done,
  // shared pin 1 and pin 9 inputs
  input  wire logic       companion_link_clock,
  input  wire logic       sync_pin,
  // routed functions
  output var  logic       link_clock_out,
  output var  logic       sync_clock_out,
  output var  logic [7:0] channel_enable,
  // converter pin functions
  output var  logic       conv1_switch_node,
  output var  logic       conv2_switch_node,
  // event and power-good sources
  input  wire logic       interrupt_req,
  input  wire logic       error_req,
  input  wire logic       host_reset_req,
  input  wire logic       pg_always_on,
  input  wire logic       pg_extra_one,
  input  wire logic       pg_extra_two,
  // open-drain pin 8
  input  wire logic       interrupt_pin_in,
  output var  logic       interrupt_out_n,
  output var  logic       interrupt_oe_n,
  // open-drain pin 36
  input  wire logic       error_pin_in,
  output var  logic       error_out_n,
  output var  logic       error_oe_n,
  // open-drain host reset
  input  wire logic       host_reset_pin_in,
  output var  logic       host_reset_out_n,
  output var  logic       host_reset_oe_n,
  // status
  output var  logic [2:0] pin_level,
  output var  logic       full_init_start,
  output var  logic       fast_start,
  output var  logic       in_standby,
  output var  logic       run
);

  pfsc_pkg::pfsc_top_s s_reg;
  pfsc_pkg::pfsc_top_s s_next;

  logic en_db;
  logic standby_request_db;
  logic en1_db;
  logic en2_db;
  logic en1_mode;
  logic en2_mode;

  // power-good of the group a field selects; low means not good
  function automatic logic group_good(input logic [1:0] grp,
                                      input logic       aon,
                                      input logic       one,
                                      input logic       two);
    case (grp)
      `PFSC_GROUP_ALWAYS_ON: group_good = aon;
      `PFSC_GROUP_EXTRA_ONE: group_good = one;
      `PFSC_GROUP_EXTRA_TWO: group_good = two;
      default:               group_good = 1'b1;
    endcase
  endfunction

  // registers that only take writes in standby
  function automatic logic guarded(input logic [7:0] a);
    guarded = (a == `PFSC_CONV_SWITCH_SELECT_OFS) ||
              (a == `PFSC_EXTRA_EN_ONE_SEL_OFS) ||
              (a == `PFSC_EXTRA_EN_TWO_SEL_OFS);
  endfunction

  assign en1_mode = (s_reg.en1_sel != 8'h00);
  assign en2_mode = (s_reg.en2_sel != 8'h00);

  pfsc_debounce u_deb_en (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (enable_in),
    .dout  (en_db)
  );

  pfsc_debounce u_deb_standby_request (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (standby_request),
    .dout  (standby_request_db)
  );

  pfsc_debounce u_deb_en1 (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (en1_mode & companion_link_clock),
    .dout  (en1_db)
  );

  pfsc_debounce u_deb_en2 (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (en2_mode & sync_pin),
    .dout  (en2_db)
  );

  always_comb begin
    logic       wr_ok;
    logic [1:0] grp1;
    logic [1:0] grp2;
    wr_ok = 1'b0;
    grp1  = s_reg.aux_sel[`PFSC_AUX_RESET_ONE_MSB:`PFSC_AUX_RESET_ONE_LSB];
    grp2  = s_reg.aux_sel[`PFSC_AUX_RESET_TWO_MSB:`PFSC_AUX_RESET_TWO_LSB];
    s_next = s_reg;
    s_next.full_init_start = 1'b0;
    s_next.fast_start      = 1'b0;
    s_next.wr_refused      = 1'b0;

    // register writes
    if (reg_wr) begin
      wr_ok = !guarded(reg_addr) ||
              (s_reg.state == pfsc_pkg::PFSC_STANDBY);
      s_next.wr_refused = !wr_ok;
      if (wr_ok) begin
        case (reg_addr)
          `PFSC_CONV_SWITCH_SELECT_OFS: s_next.conv_sel = reg_wdata;
          `PFSC_AUX_RESET_PIN_SEL_OFS:  s_next.aux_sel  = reg_wdata;
          `PFSC_EXTRA_EN_ONE_SEL_OFS:   s_next.en1_sel  = reg_wdata;
          `PFSC_EXTRA_EN_TWO_SEL_OFS:   s_next.en2_sel  = reg_wdata;
          default:                      s_next.rdata    = s_reg.rdata;
        endcase
      end
    end

    // register reads; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `PFSC_CONV_SWITCH_SELECT_OFS: s_next.rdata = s_reg.conv_sel;
        `PFSC_AUX_RESET_PIN_SEL_OFS:  s_next.rdata = s_reg.aux_sel;
        `PFSC_EXTRA_EN_ONE_SEL_OFS:   s_next.rdata = s_reg.en1_sel;
        `PFSC_EXTRA_EN_TWO_SEL_OFS:   s_next.rdata = s_reg.en2_sel;
        default:                      s_next.rdata = 8'h00;
      endcase
    end

    // main enable / standby sequence
    case (s_reg.state)
      pfsc_pkg::PFSC_OFF: begin
        if (en_db) begin
          s_next.state           = pfsc_pkg::PFSC_INIT;
          s_next.full_init_start = 1'b1;
        end
      end
      pfsc_pkg::PFSC_INIT: begin
        if (!en_db) begin
          s_next.state = pfsc_pkg::PFSC_OFF;
        end else if (init_done) begin
          s_next.state = pfsc_pkg::PFSC_ACTIVE;
        end
      end
      pfsc_pkg::PFSC_ACTIVE: begin
        if (!en_db) begin
          s_next.state = standby_request_db ? pfsc_pkg::PFSC_STANDBY
                                 : pfsc_pkg::PFSC_OFF;
        end
      end
      pfsc_pkg::PFSC_STANDBY: begin
        if (en_db) begin
          s_next.state      = pfsc_pkg::PFSC_ACTIVE;
          s_next.fast_start = 1'b1;
        end else if (!standby_request_db) begin
          s_next.state = pfsc_pkg::PFSC_OFF;
        end
      end
      default: begin
        s_next.state = pfsc_pkg::PFSC_OFF;
      end
    endcase

    s_next.in_standby = (s_next.state == pfsc_pkg::PFSC_STANDBY);
    s_next.run        = (s_next.state == pfsc_pkg::PFSC_ACTIVE);

    // shared pin routing
    s_next.link_clock = !en1_mode & companion_link_clock;
    s_next.sync_clock = !en2_mode & sync_pin;
    s_next.ch_enable  = (s_reg.en1_sel & {8{en1_db}}) |
                        (s_reg.en2_sel & {8{en2_db}});

    s_next.conv1_switch_node =
      s_reg.conv_sel[`PFSC_CONV1_INTERNAL_SWITCH_BIT];
    s_next.conv2_switch_node =
      s_reg.conv_sel[`PFSC_CONV2_INTERNAL_SWITCH_BIT];

    // open-drain pins: oe_n low pulls the wire low
    if (grp1 == `PFSC_GROUP_NONE) begin
      s_next.int_oe_n = !interrupt_req;
    end else begin
      s_next.int_oe_n = group_good(grp1, pg_always_on,
                                   pg_extra_one, pg_extra_two);
    end
    if (grp2 == `PFSC_GROUP_NONE) begin
      s_next.err_oe_n = !error_req;
    end else begin
      s_next.err_oe_n = group_good(grp2, pg_always_on,
                                   pg_extra_one, pg_extra_two);
    end
    s_next.host_rst_oe_n = s_next.run & !host_reset_req;

    s_next.pin_level = {host_reset_pin_in, error_pin_in, interrupt_pin_in};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg               <= '0;
      s_reg.state         <= pfsc_pkg::PFSC_OFF;
      s_reg.conv_sel      <= `PFSC_CONV_SWITCH_SELECT_RST;
      s_reg.aux_sel       <= `PFSC_AUX_RESET_PIN_SEL_RST;
      s_reg.en1_sel       <= `PFSC_EXTRA_EN_ONE_SEL_RST;
      s_reg.en2_sel       <= `PFSC_EXTRA_EN_TWO_SEL_RST;
      s_reg.int_oe_n      <= 1'b1;
      s_reg.err_oe_n      <= 1'b1;
      s_reg.host_rst_oe_n <= 1'b0;
      s_reg.pin_level     <= 3'h7;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata         = s_reg.rdata;
  assign reg_wr_refused    = s_reg.wr_refused;
  assign link_clock_out    = s_reg.link_clock;
  assign sync_clock_out    = s_reg.sync_clock;
  assign channel_enable    = s_reg.ch_enable;
  assign conv1_switch_node = s_reg.conv1_switch_node;
  assign conv2_switch_node = s_reg.conv2_switch_node;
  assign interrupt_out_n   = 1'b0;
  assign interrupt_oe_n    = s_reg.int_oe_n;
  assign error_out_n       = 1'b0;
  assign error_oe_n        = s_reg.err_oe_n;
  assign host_reset_out_n  = 1'b0;
  assign host_reset_oe_n   = s_reg.host_rst_oe_n;
  assign pin_level         = s_reg.pin_level;
  assign full_init_start   = s_reg.full_init_start;
  assign fast_start        = s_reg.fast_start;
  assign in_standby        = s_reg.in_standby;
  assign run               = s_reg.run;

endmodule // pfsc_top
`default_nettype wire

// ===== sim/pfsc_assertions.sv
// Purpose: port checks of pin function and standby control
// Assumes: ce held high
// Notes:   mirrors follow the writes that are accepted
`timescale 1ns/1ps
`default_nettype none
module pfsc_checker (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr_refused,
  // pins and sources
  input wire logic       enable_in,
  input wire logic       standby_request,
  input wire logic       companion_link_clock,
  input wire logic       sync_pin,
  input wire logic       interrupt_req,
  input wire logic       error_req,
  input wire logic       host_reset_req,
  input wire logic       pg_always_on,
  input wire logic       pg_extra_one,
  input wire logic       pg_extra_two,
  // outputs
  input wire logic       link_clock_out,
  input wire logic       sync_clock_out,
  input wire logic       conv1_switch_node,
  input wire logic       conv2_switch_node,
  input wire logic       interrupt_oe_n,
  input wire logic       error_oe_n,
  input wire logic       host_reset_oe_n,
  input wire logic       full_init_start,
  input wire logic       fast_start,
  input wire logic       in_standby,
  input wire logic       run
);
  logic [7:0]  m_conv, m_aux, m_en1, m_en2;
  logic [11:0] en_cnt, sb_cnt;
  wire logic [3:0] pgv = {pg_extra_two, pg_extra_one, pg_always_on, 1'b0};
  wire logic pg1 = pgv[m_aux[1:0]];
  wire logic pg2 = pgv[m_aux[5:4]];
  wire logic grd = reg_addr == 8'h0a || reg_addr == 8'h3e || reg_addr == 8'h3f;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {m_conv, m_aux, m_en1, m_en2} <= 32'h0;
      {en_cnt, sb_cnt} <= 24'h0;
    end else begin
      en_cnt <= enable_in ? en_cnt + {11'h0, en_cnt != 12'hfff} : 12'h0;
      sb_cnt <= standby_request ? sb_cnt + {11'h0, sb_cnt != 12'hfff} : 12'h0;
      if (reg_wr && reg_addr == 8'h3d) m_aux <= reg_wdata;
      if (reg_wr && in_standby && reg_addr == 8'h0a) m_conv <= reg_wdata;
      if (reg_wr && in_standby && reg_addr == 8'h3e) m_en1 <= reg_wdata;
      if (reg_wr && in_standby && reg_addr == 8'h3f) m_en2 <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_LINK_ROUTE: assert property (m_en1 == 8'h0 && $past(m_en1) == 8'h0 |=>
    link_clock_out == $past(companion_link_clock)) else $error("link clock");
  AST_LINK_BLOCK: assert property (m_en1 != 8'h0 && $past(m_en1) != 8'h0 |=>
    !link_clock_out) else $error("link clock not blocked");
  AST_SYNC_ROUTE: assert property (m_en2 == 8'h0 && $past(m_en2) == 8'h0 |=>
    sync_clock_out == $past(sync_pin)) else $error("sync clock");
  AST_INT_PIN: assert property (m_aux[1:0] == 2'h0 |=>
    interrupt_oe_n == !$past(interrupt_req)) else $error("interrupt pin");
  AST_AUX1_PG: assert property (m_aux[1:0] != 2'h0 |=>
    interrupt_oe_n == $past(pg1)) else $error("aux reset one");
  AST_ERR_PIN: assert property (m_aux[5:4] == 2'h0 |=>
    error_oe_n == !$past(error_req)) else $error("error pin");
  AST_AUX2_PG: assert property (m_aux[5:4] != 2'h0 |=>
    error_oe_n == $past(pg2)) else $error("aux reset two");
  AST_CONV_SEL: assert property (m_conv == $past(m_conv) |->
    {conv2_switch_node, conv1_switch_node} == m_conv[1:0]) else $error("conv");
  AST_WR_GUARD: assert property (reg_wr |=>
    reg_wr_refused == $past(grd && !in_standby)) else $error("guard");
  AST_INIT_DEB: assert property (full_init_start |-> en_cnt >= 12'd2500)
    else $error("enable not debounced");
  AST_SBY_DEB: assert property ($rose(in_standby) |-> sb_cnt >= 12'd2500)
    else $error("standby not debounced");
  AST_FAST: assert property (fast_start |-> run && !full_init_start)
    else $error("fast start");
  AST_HOST_RST: assert property (!run || $past(host_reset_req) |->
    !host_reset_oe_n) else $error("host reset");
  cover property (fast_start);
  cover property (full_init_start);
  cover property (reg_wr_refused);
endmodule // pfsc_checker
bind pfsc_top pfsc_checker u_pfsc_checker (.clk, .rst_n, .reg_wr, .reg_addr,
  .reg_wdata, .reg_wr_refused, .enable_in, .standby_request,
  .companion_link_clock, .sync_pin, .interrupt_req, .error_req,
  .host_reset_req, .pg_always_on, .pg_extra_one, .pg_extra_two,
  .link_clock_out, .sync_clock_out, .conv1_switch_node, .conv2_switch_node,
  .interrupt_oe_n, .error_oe_n, .host_reset_oe_n, .full_init_start,
  .fast_start, .in_standby, .run);
`default_nettype wire

// ===== sim/pfsc_host_model.sv
// Purpose: host side of the open-drain wires
// Assumes: pull-up on every wire
// Notes:   pull_dn lets the host hold a wire low too
`timescale 1ns/1ps
`default_nettype none
module pfsc_host_model (
  // device enables, low pulls the wire
  input  wire logic [2:0] oe_n,
  // host pull-downs
  input  wire logic [2:0] pull_dn,
  // wire levels
  output var  logic [2:0] lvl
);
  assign lvl = oe_n & ~pull_dn;
endmodule // pfsc_host_model
`default_nettype wire

// ===== sim/pfsc_tb_top.sv
// Purpose: self-checking bench of pfsc_top
// Assumes: init_done high, ce high
// Notes:   random pin traffic from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module pfsc_tb_top;
  logic clk, rst_n, reg_wr, reg_rd, enable_in, standby_request, r;
  logic companion_link_clock, sync_pin, interrupt_req, error_req;
  logic host_reset_req, pg_always_on, pg_extra_one, pg_extra_two;
  logic link_clock_out, sync_clock_out, conv1_switch_node, conv2_switch_node;
  logic interrupt_oe_n, error_oe_n, host_reset_oe_n, reg_wr_refused;
  logic full_init_start, fast_start, in_standby, run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, channel_enable, d, aux, e1, e2;
  logic [2:0] pull_dn, lvl, pin_level;
  int err_count, compares, n_init, n_fast, cyc, t_init, t0, seed, v, i;
  pfsc_top u_pfsc_top (.clk, .rst_n, .ce(1'b1), .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_wr_refused, .enable_in, .standby_request,
    .init_done(1'b1), .companion_link_clock, .sync_pin, .link_clock_out,
    .sync_clock_out, .channel_enable, .conv1_switch_node, .conv2_switch_node,
    .interrupt_req, .error_req, .host_reset_req, .pg_always_on, .pg_extra_one,
    .pg_extra_two, .interrupt_pin_in(lvl[0]), .interrupt_out_n(),
    .interrupt_oe_n, .error_pin_in(lvl[1]), .error_out_n(), .error_oe_n,
    .host_reset_pin_in(lvl[2]), .host_reset_out_n(), .host_reset_oe_n,
    .pin_level, .full_init_start, .fast_start, .in_standby, .run);
  pfsc_host_model u_pfsc_host_model (.oe_n({host_reset_oe_n, error_oe_n,
    interrupt_oe_n}), .pull_dn, .lvl);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (full_init_start === 1'b1) n_init++;
    if (full_init_start === 1'b1) t_init = cyc;
    if (fast_start === 1'b1) n_fast++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 r = reg_wr_refused;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_on(input logic sel);
    repeat (3000) begin
      @(posedge clk);
      #1;
      if ((sel ? in_standby : run) === 1'b1) break;
    end
  endtask
  function automatic logic od_exp(logic [1:0] c, logic req, logic [3:0] pg);
    return (c == 2'h0) ? !req : pg[c];
  endfunction
  task automatic test_done;
    $display("counts: compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    test_done;
  end
  initial begin
    seed = 32'h565bb406;
    {rst_n, reg_wr, reg_rd, enable_in, standby_request, r} = 6'h0;
    {companion_link_clock, sync_pin, interrupt_req, error_req} = 4'h0;
    {host_reset_req, pg_always_on, pg_extra_one, pg_extra_two} = 4'h0;
    {reg_addr, reg_wdata, pull_dn} = 19'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rd(i == 4 ? 8'h55 : (i == 0 ? 8'h0a : 8'h3c + i[7:0]));
      chk(d, 8'h00);
    end
    chk({7'h0, host_reset_oe_n}, 8'h00);
    wr(8'h0a, 8'h03);
    chk({7'h0, r}, 8'h01);
    $display("test reset and guard done");
    for (i = 0; i < 16; i++) begin
      aux = {2'h0, i[3:2], 2'h0, i[1:0]};
      wr(8'h3d, aux);
      repeat (4) begin
        @(posedge clk);
        v = $random(seed);
        {sync_pin, companion_link_clock, pg_extra_two} <= v[6:4];
        {pg_extra_one, pg_always_on, error_req, interrupt_req} <= v[3:0];
        pull_dn <= v[9:7];
        @(posedge clk);
        #1;
        chk({7'h0, interrupt_oe_n}, {7'h0, od_exp(aux[1:0], v[0],
          {v[4:2], 1'b0})});
        chk({7'h0, error_oe_n}, {7'h0, od_exp(aux[5:4], v[1],
          {v[4:2], 1'b0})});
        chk({6'h0, sync_clock_out, link_clock_out}, {6'h0, v[6:5]});
      end
      // wire levels read back once the open-drain enables have settled
      repeat (2) @(posedge clk);
      #1;
      chk({5'h0, pin_level}, {5'h0, lvl});
    end
    $display("test pin functions done");
    enable_in <= 1'b1;
    repeat (2000) @(posedge clk);
    enable_in <= 1'b0;
    repeat (2600) @(posedge clk);
    chk({run, 7'h0} | n_init[7:0], 8'h00);
    enable_in <= 1'b1;
    t0 = cyc;
    wait_on(1'b0);
    repeat (2) @(posedge clk);
    chk(n_init[7:0], 8'h01);
    chk({7'h0, (t_init - t0) inside {[2500:2504]}}, 8'h01);
    chk({7'h0, host_reset_oe_n}, 8'h01);
    $display("test full start done");
    standby_request <= 1'b1;
    {companion_link_clock, sync_pin} <= 2'h0;
    repeat (2600) @(posedge clk);
    enable_in <= 1'b0;
    wait_on(1'b1);
    chk({in_standby, run}, 8'h02);
    d = $random(seed);
    e1 = $random(seed) | 1;
    e2 = $random(seed) | 2;
    wr(8'h0a, d);
    chk({7'h0, r}, 8'h00);
    wr(8'h3e, e1);
    wr(8'h3f, e2);
    repeat (3) @(posedge clk);
    chk({6'h0, conv2_switch_node, conv1_switch_node}, {6'h0, d[1:0]});
    {companion_link_clock, sync_pin} <= 2'h3;
    repeat (2000) @(posedge clk);
    chk(channel_enable, 8'h00);
    repeat (600) @(posedge clk);
    chk(channel_enable, e1 | e2);
    chk({6'h0, sync_clock_out, link_clock_out}, 8'h00);
    $display("test standby done");
    enable_in <= 1'b1;
    wait_on(1'b0);
    repeat (2) @(posedge clk);
    chk({n_fast[3:0], n_init[3:0]}, 8'h11);
    $display("test fast start done");
    test_done;
  end
endmodule // pfsc_tb_top
`default_nettype wire
